// *** hdl/ltpc_regs.sv ***
// Purpose: Emitter and power control registers behind the serial port,
//          with current decode, power-down steering and diagnostics timer.
// Assumes: Frame of 32 bits, MSB first, sampled on rising serial clock;
//          first byte is read flag (bit 7) and 7-bit address.
// Notes:   Serial pins are oversampled, so the serial clock must stay
//          well below a quarter of clock_i.
`timescale 1ns/1ps
`include "ltpc_map.svh"
module ltpc_regs #(
	parameter int unsigned DIAG_SHORT_CYC = `LTPC_DIAG_SHORT_CYC,
	parameter int unsigned DIAG_LONG_CYC  = `LTPC_DIAG_LONG_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        spi_clk_i,
	input  wire logic        spi_sel_n_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	output logic             spi_miso_oe_o,
	input  wire logic        dyn_phase_i,
	input  wire logic        conv_ready_i,
	input  wire logic        diag_start_i,
	output logic             conv_ready_o,
	output logic             conv_ready_oe_o,
	output logic             fault_check_done_pin_o,
	output logic             fault_check_done_pin_oe_o,
	output logic [1:0]       tx_ref_code_o,
	output logic [9:0]       tx_ref_mv_o,
	output logic [6:0]       full_scale_ma_o,
	output logic             range_invalid_o,
	output logic [14:0]      first_emitter_drive_o,
	output logic [14:0]      second_emitter_drive_o,
	output logic             driver_topology_select_o,
	output logic             oscillator_enable_o,
	output logic             transmitter_pd_o,
	output logic             converter_part_pd_o,
	output logic             transimpedance_pd_o,
	output logic             converter_rest_pd_o,
	output logic             receiver_pd_o,
	output logic             diag_pd_o,
	output logic             diag_busy_o
);
	logic [1:0]           rst_pipe_reg;
	logic                 rst_n;
	logic [2:0]           pins_q;
	logic                 sel_n_s;
	logic                 sclk_s;
	logic                 mosi_s;
	logic                 sclk_prev_reg;
	ltpc_pkg::ltpc_bitcnt_t cnt_reg;
	logic [31:0]          shift_reg;
	logic [31:0]          shift_next;
	logic                 rd_reg;
	ltpc_pkg::ltpc_word_t out_reg;
	ltpc_pkg::ltpc_word_t emitter_reg;
	ltpc_pkg::ltpc_word_t control_reg;
	ltpc_pkg::ltpc_word_t rd_data;
	ltpc_pkg::ltpc_addr_t rx_addr;
	ltpc_pkg::ltpc_addr_t wr_addr;
	ltpc_pkg::ltpc_word_t wr_data;
	logic                 rise;
	logic                 fall;
	logic                 byte_done;
	logic                 frame_done;
	logic                 wr_emitter;
	logic                 wr_control;
	logic [1:0]           span;
	logic [1:0]           ref_code;
	logic [9:0]           ref_mv;
	logic [6:0]           fs_ma;
	logic                 fs_bad;
	logic                 span_off;
	logic                 fe_off;
	logic [31:0]          diag_cnt_reg;
	logic [31:0]          diag_len;
	logic                 diag_go;
	logic [7:0]           first_code;
	logic [7:0]           second_code;
	logic [14:0]          first_drive;
	logic [14:0]          second_drive;

	// Reset is released through two flops so every flop leaves reset
	// on the same edge.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_reg[1];

	ltpc_sync #(
		.W         (3),
		.RESET_VAL (3'h4)
	) u_pin_sync (
		.clock_i  (clock_i),
		.resetn_i (rst_n),
		.d_i      ({spi_sel_n_i, spi_clk_i, spi_mosi_i}),
		.q_o      (pins_q)
	);
	assign sel_n_s = pins_q[2];
	assign sclk_s  = pins_q[1];
	assign mosi_s  = pins_q[0];

	// Serial framing
	assign rise       = sclk_s & ~sclk_prev_reg & ~sel_n_s
		& (cnt_reg < `LTPC_FRAME_BITS);
	assign fall       = ~sclk_s & sclk_prev_reg & ~sel_n_s;
	assign shift_next = {shift_reg[30:0], mosi_s};
	assign byte_done  = rise & (cnt_reg == `LTPC_ADDR_BITS - 6'd1);
	assign frame_done = rise & (cnt_reg == `LTPC_FRAME_BITS - 6'd1);
	assign rx_addr    = shift_next[6:0];
	assign wr_addr    = shift_next[30:24];
	assign wr_data    = shift_next[23:0];
	assign wr_emitter = frame_done & ~rd_reg
		& (wr_addr == `LTPC_OFS_EMITTER);
	// Spare location takes no write, so it stays at zero
	assign wr_control = frame_done & ~rd_reg
		& (wr_addr == `LTPC_OFS_CONTROL);

	assign rd_data = (rx_addr == `LTPC_OFS_EMITTER) ? emitter_reg :
		(rx_addr == `LTPC_OFS_CONTROL) ? control_reg :
		(rx_addr == `LTPC_OFS_SPARE) ? `LTPC_SPARE_RESET :
		24'h000000;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			cnt_reg       <= 6'h00;
			shift_reg     <= 32'h00000000;
			rd_reg        <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			if (sel_n_s) begin
				cnt_reg <= 6'h00;
				rd_reg  <= 1'b0;
			end else if (rise) begin
				cnt_reg   <= cnt_reg + 6'd1;
				shift_reg <= shift_next;
				if (byte_done) begin
					rd_reg <= shift_next[7];
				end
			end
		end
	end

	// Read data leaves MSB first; a bit is shifted on the falling edge
	// after the host has sampled the previous one.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= 24'h000000;
		end else if (byte_done) begin
			out_reg <= rd_data;
		end else if (fall && cnt_reg > `LTPC_ADDR_BITS) begin
			out_reg <= {out_reg[22:0], 1'b0};
		end
	end
	assign spi_miso_o    = out_reg[23];
	assign spi_miso_oe_o = ~sel_n_s & rd_reg & (cnt_reg >= `LTPC_ADDR_BITS);

	// Register file; reserved bits are masked so they read back zero
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			emitter_reg <= `LTPC_EMITTER_RESET;
			control_reg <= `LTPC_CONTROL_RESET;
		end else begin
			if (wr_emitter) begin
				emitter_reg <= wr_data & `LTPC_EMITTER_WMASK;
			end
			if (wr_control) begin
				control_reg <= wr_data & `LTPC_CONTROL_WMASK;
			end
		end
	end

	// Current decode
	assign span     = emitter_reg[`LTPC_SPAN_MSB:`LTPC_SPAN_LSB];
	assign ref_code = control_reg[`LTPC_REF_MSB:`LTPC_REF_LSB];
	assign ref_mv   = (ref_code == 2'h0) ? `LTPC_REF_MV_0 :
		(ref_code == 2'h1) ? `LTPC_REF_MV_1 :
		(ref_code == 2'h2) ? `LTPC_REF_MV_2 : `LTPC_REF_MV_3;
	assign span_off = (span == 2'h3);

	// Both factors are widened to 15 bits before the product so it
	// cannot wrap; 255 times 100 mA still fits.
	assign first_code   = emitter_reg[`LTPC_FIRST_MSB:`LTPC_FIRST_LSB];
	assign second_code  = emitter_reg[`LTPC_SECOND_MSB:`LTPC_SECOND_LSB];
	assign first_drive  = {7'h00, first_code} * {8'h00, fs_ma};
	assign second_drive = {7'h00, second_code} * {8'h00, fs_ma};

	// Codes 00 and 10 have no defined current above 0.5 V; those
	// combinations give zero current and raise range_invalid_o.
	always_comb begin
		fs_ma  = 7'd0;
		fs_bad = 1'b0;
		unique case (span)
			2'h1: begin
				unique case (ref_code)
					2'h0: fs_ma = `LTPC_FS_25MA;
					2'h1: fs_ma = `LTPC_FS_50MA;
					2'h3: fs_ma = `LTPC_FS_75MA;
					2'h2: fs_ma = `LTPC_FS_100MA;
				endcase
			end
			2'h0, 2'h2: begin
				if (ref_code == 2'h0) begin
					fs_ma = `LTPC_FS_50MA;
				end else if (ref_code == 2'h1) begin
					fs_ma = `LTPC_FS_100MA;
				end else begin
					fs_bad = 1'b1;
				end
			end
			2'h3: fs_ma = 7'd0;
		endcase
	end

	assign fe_off = control_reg[`LTPC_BIT_FE_OFF];

	// Decoded outputs are registered to keep them glitch free
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_ref_code_o            <= 2'h0;
			tx_ref_mv_o              <= `LTPC_REF_MV_0;
			full_scale_ma_o          <= `LTPC_FS_50MA;
			range_invalid_o          <= 1'b0;
			first_emitter_drive_o    <= 15'h0000;
			second_emitter_drive_o   <= 15'h0000;
			driver_topology_select_o <= 1'b0;
			oscillator_enable_o      <= 1'b1;
			transmitter_pd_o         <= 1'b0;
			converter_part_pd_o      <= 1'b0;
			transimpedance_pd_o      <= 1'b0;
			converter_rest_pd_o      <= 1'b0;
			receiver_pd_o            <= 1'b0;
			diag_pd_o                <= 1'b0;
			conv_ready_o             <= 1'b0;
		end else begin
			tx_ref_code_o   <= ref_code;
			tx_ref_mv_o     <= ref_mv;
			full_scale_ma_o <= fs_ma;
			range_invalid_o <= fs_bad;
			// Drive in units of 1/256 mA: code times full scale
			first_emitter_drive_o  <= first_drive;
			second_emitter_drive_o <= second_drive;
			driver_topology_select_o <=
				control_reg[`LTPC_BIT_TOPOLOGY];
			oscillator_enable_o <=
				~control_reg[`LTPC_BIT_OSC_BYPASS];
			transmitter_pd_o <= fe_off | span_off
				| control_reg[`LTPC_BIT_TX_OFF]
				| (dyn_phase_i & control_reg[`LTPC_BIT_SLEEP_TX]);
			converter_part_pd_o <= fe_off | control_reg[`LTPC_BIT_RX_OFF]
				| (dyn_phase_i
				& control_reg[`LTPC_BIT_SLEEP_CPART]);
			transimpedance_pd_o <= fe_off | control_reg[`LTPC_BIT_RX_OFF]
				| (dyn_phase_i
				& control_reg[`LTPC_BIT_SLEEP_TIA]);
			converter_rest_pd_o <= fe_off | control_reg[`LTPC_BIT_RX_OFF]
				| (dyn_phase_i
				& control_reg[`LTPC_BIT_SLEEP_CREST]);
			receiver_pd_o <= fe_off | control_reg[`LTPC_BIT_RX_OFF];
			diag_pd_o     <= fe_off;
			conv_ready_o  <= conv_ready_i;
		end
	end

	// Pins float while the float bit is set
	assign conv_ready_oe_o           = ~control_reg[`LTPC_BIT_FLOAT];
	assign fault_check_done_pin_oe_o = ~control_reg[`LTPC_BIT_FLOAT];

	// Diagnostics timer; a start during a run or power-down is ignored.
	// The run length is taken at the start, so flipping the speed bit
	// mid-run does not stretch or cut the current run.
	assign diag_len = control_reg[`LTPC_BIT_LONG_DIAG]
		? DIAG_LONG_CYC : DIAG_SHORT_CYC;
	assign diag_go  = diag_start_i & ~diag_busy_o & ~fe_off;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			diag_cnt_reg           <= 32'h00000000;
			diag_busy_o            <= 1'b0;
			fault_check_done_pin_o <= 1'b0;
		end else if (fe_off) begin
			diag_cnt_reg <= 32'h00000000;
			diag_busy_o  <= 1'b0;
		end else if (diag_go) begin
			diag_cnt_reg           <= diag_len - 32'd1;
			diag_busy_o            <= 1'b1;
			fault_check_done_pin_o <= 1'b0;
		end else if (diag_busy_o) begin
			if (diag_cnt_reg == 32'h00000000) begin
				diag_busy_o            <= 1'b0;
				fault_check_done_pin_o <= 1'b1;
			end else begin
				diag_cnt_reg <= diag_cnt_reg - 32'd1;
			end
		end
	end
endmodule : ltpc_regs

// *** hdl/ltpc_map.svh ***
// Purpose: Offsets, field positions, reset values and timing figures
//          for the emitter and power control register bank.
// Assumes: Register index is the 7-bit address of the serial port frame.
// Notes:   Definitions only.
// Summary of operation
// - Range and reference select full-scale emitter current
// - Emitter drive equals code over 256 times full-scale
// - Bit 20 sleeps transmitter in dynamic phase
// - Bit 14 sleeps part of converter dynamically
// - Bit 4 sleeps transimpedance amplifier dynamically
// - Bit 3 sleeps rest of converter dynamically
// - Bits 18:17 select transmitter reference voltage
// - Bit 11 chooses H-bridge or push-pull driver
// - Bit 10 floats conversion-ready and done pins
// - Bit 9 bypasses crystal oscillator for external clock
// - Bit 8 selects 8 ms or 16 ms diagnostics
// - Bit 2 powers down transmitter only
// - Bit 1 powers down receiver only
// - Bit 0 powers down whole front end
// - Address 24h spare, reads zero after reset
// - Emitter range field at bits 17:16
// - Emitter codes at 15:8 and 7:0, reset zero
`ifndef LTPC_MAP_SVH
`define LTPC_MAP_SVH

`define LTPC_OFS_EMITTER      7'h22
`define LTPC_OFS_CONTROL      7'h23
`define LTPC_OFS_SPARE        7'h24

`define LTPC_EMITTER_RESET    24'h000000
`define LTPC_CONTROL_RESET    24'h000000
`define LTPC_SPARE_RESET      24'h000000
`define LTPC_EMITTER_WMASK    24'h03FFFF
`define LTPC_CONTROL_WMASK    24'h164F1F

`define LTPC_SPAN_MSB         17
`define LTPC_SPAN_LSB         16
`define LTPC_FIRST_MSB        15
`define LTPC_FIRST_LSB        8
`define LTPC_SECOND_MSB       7
`define LTPC_SECOND_LSB       0

`define LTPC_BIT_SLEEP_TX     20
`define LTPC_REF_MSB          18
`define LTPC_REF_LSB          17
`define LTPC_BIT_SLEEP_CPART  14
`define LTPC_BIT_TOPOLOGY     11
`define LTPC_BIT_FLOAT        10
`define LTPC_BIT_OSC_BYPASS   9
`define LTPC_BIT_LONG_DIAG    8
`define LTPC_BIT_SLEEP_TIA    4
`define LTPC_BIT_SLEEP_CREST  3
`define LTPC_BIT_TX_OFF       2
`define LTPC_BIT_RX_OFF       1
`define LTPC_BIT_FE_OFF       0

`define LTPC_REF_MV_0         10'd250
`define LTPC_REF_MV_1         10'd500
`define LTPC_REF_MV_2         10'd1000
`define LTPC_REF_MV_3         10'd750
`define LTPC_FS_25MA          7'd25
`define LTPC_FS_50MA          7'd50
`define LTPC_FS_75MA          7'd75
`define LTPC_FS_100MA         7'd100

`define LTPC_CLK_KHZ          20000
`define LTPC_DIAG_SHORT_MS    8
`define LTPC_DIAG_LONG_MS     16
`define LTPC_DIAG_SHORT_CYC   (`LTPC_DIAG_SHORT_MS * `LTPC_CLK_KHZ)
`define LTPC_DIAG_LONG_CYC    (`LTPC_DIAG_LONG_MS * `LTPC_CLK_KHZ)
`define LTPC_FRAME_BITS       6'd32
`define LTPC_ADDR_BITS        6'd8

`endif

// *** hdl/ltpc_pkg.sv ***
// Purpose: Shared types of the emitter and power control register bank.
// Assumes: Constants live in ltpc_map.svh.
// Notes:   Types only.
package ltpc_pkg;
	typedef logic [23:0] ltpc_word_t;
	typedef logic [6:0]  ltpc_addr_t;
	typedef logic [5:0]  ltpc_bitcnt_t;
endpackage : ltpc_pkg

// *** hdl/ltpc_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clock_i.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module ltpc_sync #(
	parameter int unsigned W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clock_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_reg <= RESET_VAL;
			q_o      <= RESET_VAL;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : ltpc_sync

// *** test/ltpc_regs_asserts.sv ***
// Purpose: Port-level checks of the emitter and power control bank.
// Assumes: One clock domain; diagnostics counts come in as parameters.
// Notes:   Bound to every ltpc_regs instance.
`timescale 1ns/1ps
module ltpc_regs_asserts #(
	parameter int unsigned DIAG_SHORT_CYC = 20,
	parameter int unsigned DIAG_LONG_CYC  = 40
) (
	input wire logic       clock_i,
	input wire logic       resetn_i,
	input wire logic       dyn_phase_i,
	input wire logic       diag_start_i,
	input wire logic       conv_ready_oe_o,
	input wire logic       fault_check_done_pin_oe_o,
	input wire logic       fault_check_done_pin_o,
	input wire logic [1:0] tx_ref_code_o,
	input wire logic [9:0] tx_ref_mv_o,
	input wire logic [6:0] full_scale_ma_o,
	input wire logic       range_invalid_o,
	input wire logic       transmitter_pd_o,
	input wire logic       converter_part_pd_o,
	input wire logic       transimpedance_pd_o,
	input wire logic       converter_rest_pd_o,
	input wire logic       receiver_pd_o,
	input wire logic       diag_pd_o,
	input wire logic       diag_busy_o
);
	logic [19:0] busy_cnt_reg;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Length of the current diagnostics run, cleared when idle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			busy_cnt_reg <= '0;
		else if (diag_busy_o)
			busy_cnt_reg <= busy_cnt_reg + 20'h00001;
		else
			busy_cnt_reg <= '0;
	end
	AST_FE_OFF: assert property (diag_pd_o |->
		transmitter_pd_o && receiver_pd_o) else $error("front end off leaks");
	AST_RX_OFF: assert property (receiver_pd_o |->
		converter_part_pd_o && transimpedance_pd_o && converter_rest_pd_o)
		else $error("receiver off leaks");
	AST_DYN_ONLY: assert property ((converter_part_pd_o ||
		transimpedance_pd_o || converter_rest_pd_o) && !receiver_pd_o
		|-> $past(dyn_phase_i)) else $error("sleep outside dynamic phase");
	AST_REF_MV: assert property (tx_ref_mv_o == (tx_ref_code_o == 2'h0 ?
		10'h0FA : tx_ref_code_o == 2'h1 ? 10'h1F4 : tx_ref_code_o == 2'h2 ?
		10'h3E8 : 10'h2EE)) else $error("reference voltage decode wrong");
	AST_INVALID: assert property (range_invalid_o |->
		full_scale_ma_o == 7'h00) else $error("unusable range not zero");
	AST_FS_LOW: assert property (full_scale_ma_o == 7'h19 |->
		tx_ref_code_o == 2'h0) else $error("25 mA at wrong reference");
	AST_FLOAT: assert property (
		conv_ready_oe_o == fault_check_done_pin_oe_o)
		else $error("output pins float apart");
	AST_DIAG_START: assert property ($rose(diag_busy_o) |->
		$past(diag_start_i)) else $error("diagnostics began unasked");
	AST_DIAG_LEN: assert property ($fell(diag_busy_o) && !diag_pd_o |->
		busy_cnt_reg == DIAG_SHORT_CYC || busy_cnt_reg == DIAG_LONG_CYC)
		else $error("diagnostics length wrong");
	AST_DIAG_DONE: assert property ($fell(diag_busy_o) && !diag_pd_o |->
		fault_check_done_pin_o) else $error("done pin not set");
	CV_DIAG: cover property ($fell(diag_busy_o) && fault_check_done_pin_o);
	CV_DYN: cover property (dyn_phase_i ##1 transimpedance_pd_o);
	CV_FLOAT: cover property (!conv_ready_oe_o);
endmodule : ltpc_regs_asserts
bind ltpc_regs ltpc_regs_asserts #(.DIAG_SHORT_CYC(DIAG_SHORT_CYC),
	.DIAG_LONG_CYC(DIAG_LONG_CYC)) chk_i (.clock_i(clock_i),
	.resetn_i(resetn_i), .dyn_phase_i(dyn_phase_i),
	.diag_start_i(diag_start_i), .conv_ready_oe_o(conv_ready_oe_o),
	.fault_check_done_pin_oe_o(fault_check_done_pin_oe_o),
	.fault_check_done_pin_o(fault_check_done_pin_o),
	.tx_ref_code_o(tx_ref_code_o), .tx_ref_mv_o(tx_ref_mv_o),
	.full_scale_ma_o(full_scale_ma_o), .range_invalid_o(range_invalid_o),
	.transmitter_pd_o(transmitter_pd_o),
	.converter_part_pd_o(converter_part_pd_o),
	.transimpedance_pd_o(transimpedance_pd_o),
	.converter_rest_pd_o(converter_rest_pd_o),
	.receiver_pd_o(receiver_pd_o), .diag_pd_o(diag_pd_o),
	.diag_busy_o(diag_busy_o));

// *** test/ltpc_host_model.sv ***
// Purpose: Host side of the serial register port.
// Assumes: Mode 0 frames of 32 bits, MSB first.
// Notes:   Phases last 4 to 5 clocks to clear the pin synchroniser.
`timescale 1ns/1ps
module ltpc_host_model (
	input  wire logic clock_i,
	input  wire logic spi_miso_i,
	input  wire logic spi_miso_oe_i,
	output logic      spi_clk_o,
	output logic      spi_sel_n_o,
	output logic      spi_mosi_o
);
	initial begin
		spi_clk_o = 1'b0;
		spi_sel_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] hdr, input logic [23:0] wdat,
		output logic [23:0] rdat);
		logic [31:0] frame;
		frame = {hdr, wdat};
		rdat = 24'h000000;
		@(posedge clock_i) spi_sel_n_o <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			@(posedge clock_i) spi_mosi_o <= frame[i];
			repeat (4) @(posedge clock_i);
			// Sampled just before the rise, long after the device shifted
			if (i < 24)
				rdat[i] = spi_miso_oe_i ? spi_miso_i : 1'bx;
			spi_clk_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			spi_clk_o <= 1'b0;
		end
		repeat (4) @(posedge clock_i);
		spi_sel_n_o <= 1'b1;
		// Released line must not keep looking like valid data
		spi_mosi_o <= ~spi_mosi_o;
		repeat (4) @(posedge clock_i);
	endtask : xfer
endmodule : ltpc_host_model

// *** test/led_tx_power_control_regs_tb.sv ***
// Purpose: Self-checking bench for the emitter and power control bank.
// Assumes: Diagnostics shortened to 20 and 40 clocks.
// Notes:   Register access only through the serial host model.
`timescale 1ns/1ps
module led_tx_power_control_regs_tb;
	logic        clock_i = 1'b0;
	logic        resetn_i, dyn_phase_i, conv_ready_i, diag_start_i;
	wire logic   s_clk, s_sel_n, s_mosi, s_miso, s_miso_oe;
	int          fail_count = 0, tests_run = 0, seed, i, n;
	logic [23:0] rdat;
	logic [7:0]  c1, c2;
	ltpc_regs #(.DIAG_SHORT_CYC(20), .DIAG_LONG_CYC(40)) uut (
		.clock_i(clock_i), .resetn_i(resetn_i), .spi_clk_i(s_clk),
		.spi_sel_n_i(s_sel_n), .spi_mosi_i(s_mosi), .spi_miso_o(s_miso),
		.spi_miso_oe_o(s_miso_oe), .dyn_phase_i(dyn_phase_i),
		.conv_ready_i(conv_ready_i), .diag_start_i(diag_start_i),
		.conv_ready_o(), .conv_ready_oe_o(), .fault_check_done_pin_o(),
		.fault_check_done_pin_oe_o(), .tx_ref_code_o(), .tx_ref_mv_o(),
		.full_scale_ma_o(), .range_invalid_o(), .first_emitter_drive_o(),
		.second_emitter_drive_o(), .driver_topology_select_o(),
		.oscillator_enable_o(), .transmitter_pd_o(), .converter_part_pd_o(),
		.transimpedance_pd_o(), .converter_rest_pd_o(), .receiver_pd_o(),
		.diag_pd_o(), .diag_busy_o());
	ltpc_host_model host (.clock_i(clock_i), .spi_miso_i(s_miso),
		.spi_miso_oe_i(s_miso_oe), .spi_clk_o(s_clk),
		.spi_sel_n_o(s_sel_n), .spi_mosi_o(s_mosi));
	always #25 clock_i = ~clock_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		logic [23:0] r;
		host.xfer({1'b0, a}, d, r);
		repeat (3) @(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [23:0] r);
		host.xfer({1'b1, a}, 24'h000000, r);
	endtask : rd
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done
	function automatic logic [9:0] mv_exp(input logic [1:0] rf);
		return rf == 2'h0 ? 10'h0FA : rf == 2'h1 ? 10'h1F4 :
			rf == 2'h2 ? 10'h3E8 : 10'h2EE;
	endfunction : mv_exp
	function automatic logic [6:0] fs_exp(input logic [1:0] rg,
		input logic [1:0] rf);
		if (rg == 2'h3)
			return 7'h00;
		if (rg == 2'h1)
			return rf == 2'h0 ? 7'h19 : rf == 2'h1 ? 7'h32 :
				rf == 2'h3 ? 7'h4B : 7'h64;
		return rf == 2'h0 ? 7'h32 : rf == 2'h1 ? 7'h64 : 7'h00;
	endfunction : fs_exp
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (40000) @(posedge clock_i);
		fail_count++;
		end_of_test;
	end
	initial begin
		seed = 32'hE19E7D0D;
		resetn_i = 1'b0;
		dyn_phase_i = 1'b0;
		conv_ready_i = 1'b0;
		diag_start_i = 1'b0;
		repeat (4) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk(uut.oscillator_enable_o, 1);
		chk(uut.tx_ref_mv_o, 10'h0FA);
		chk(uut.full_scale_ma_o, 7'h32);
		chk(uut.driver_topology_select_o, 0);
		chk({uut.diag_pd_o, uut.receiver_pd_o, uut.transmitter_pd_o}, 0);
		for (i = 34; i <= 36; i++) begin
			rd(i[6:0], rdat);
			chk(rdat, 0);
		end
		done("reset");
		for (i = 0; i < 16; i++) begin
			c1 = (i == 0) ? 8'hFF : 8'($random(seed));
			c2 = 8'($random(seed));
			wr(7'h22, {6'h00, i[3:2], c1, c2});
			wr(7'h23, {5'h00, i[1:0], 17'h00000});
			chk(uut.tx_ref_mv_o, mv_exp(i[1:0]));
			chk(uut.tx_ref_code_o, i[1:0]);
			chk(uut.range_invalid_o, !i[2] && i[1]);
			chk(uut.full_scale_ma_o, fs_exp(i[3:2], i[1:0]));
			chk(uut.first_emitter_drive_o, c1 * fs_exp(i[3:2], i[1:0]));
			chk(uut.second_emitter_drive_o, c2 * fs_exp(i[3:2], i[1:0]));
			chk(uut.transmitter_pd_o, i[3:2] == 2'h3);
		end
		rd(7'h22, rdat);
		chk(rdat, {6'h00, 2'h3, c1, c2});
		done("span");
		wr(7'h23, 24'hFFFFFF);
		rd(7'h23, rdat);
		chk(rdat, 24'h164F1F);
		chk({uut.conv_ready_oe_o, uut.fault_check_done_pin_oe_o}, 0);
		chk(uut.driver_topology_select_o, 1);
		chk(uut.oscillator_enable_o, 0);
		wr(7'h22, 24'h000000);
		for (i = 0; i < 3; i++) begin
			wr(7'h23, 24'h000001 << i);
			chk({uut.diag_pd_o, uut.receiver_pd_o, uut.transmitter_pd_o},
				i == 0 ? 3'h7 : i == 1 ? 3'h2 : 3'h1);
		end
		chk(uut.conv_ready_oe_o, 1);
		for (n = 0; n < 2; n++) begin
			@(posedge clock_i) conv_ready_i <= c2[0] ^ n[0];
			repeat (2) @(posedge clock_i);
			chk(uut.conv_ready_o, c2[0] ^ n[0]);
		end
		wr(7'h24, 24'($random(seed)));
		rd(7'h24, rdat);
		chk(rdat, 0);
		done("static");
		for (i = 0; i < 6; i++) begin
			c1 = (i == 0) ? 8'h0F : 8'($random(seed));
			wr(7'h23, {3'h0, c1[0], 5'h00, c1[1], 9'h000, c1[2], c1[3], 3'h0});
			@(posedge clock_i) dyn_phase_i <= 1'b1;
			repeat (2) @(posedge clock_i);
			chk({uut.converter_rest_pd_o, uut.transimpedance_pd_o,
				uut.converter_part_pd_o, uut.transmitter_pd_o}, c1[3:0]);
			dyn_phase_i <= 1'b0;
			repeat (2) @(posedge clock_i);
			chk({uut.converter_rest_pd_o, uut.transimpedance_pd_o,
				uut.converter_part_pd_o, uut.transmitter_pd_o}, 0);
		end
		done("dynamic");
		for (i = 0; i < 2; i++) begin
			wr(7'h23, {15'h0000, i[0], 8'h00});
			@(posedge clock_i) diag_start_i <= 1'b1;
			@(posedge clock_i) diag_start_i <= 1'b0;
			@(posedge clock_i);
			n = 0;
			while (uut.diag_busy_o === 1'b1 && n < 100) begin
				n++;
				@(posedge clock_i);
			end
			chk(n, i == 0 ? 20 : 40);
			chk(uut.fault_check_done_pin_o, 1);
		end
		done("diagnostics");
		end_of_test;
	end
endmodule : led_tx_power_control_regs_tb
